// ==== design/rpf_pkg.sv ====
package rpf_pkg;
    // Storage geometry of each byte queue
    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam logic [6:0] DEPTH_CNT = 7'h40;

    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_RXDATA = 8'h00;
    localparam logic [7:0] ADDR_TXDATA = 8'h04;
    localparam logic [7:0] ADDR_COUNTS = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0C;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h10;
    localparam logic [7:0] ADDR_IRQMASK = 8'h14;
    localparam logic [7:0] ADDR_HDRSTAT = 8'h18;

    // Counts register layout
    localparam int COUNTS_RX_LSB = 0;
    localparam int COUNTS_TX_LSB = 8;
    localparam int COUNTS_OVF_BIT = 16;
    localparam int COUNTS_UNF_BIT = 17;

    // Config register layout
    localparam int CFG_THR_LSB = 0;
    localparam int CFG_SLEEP_BIT = 4;
    localparam int CFG_FLUSH_RX_BIT = 5;
    localparam int CFG_FLUSH_TX_BIT = 6;
    localparam int CFG_PINSEL_LSB = 8;

    // Config reset values
    localparam logic [3:0] THR_RESET = 4'h7;
    localparam logic [5:0] PINSEL_RESET = 6'h00;

    // Interrupt bit positions and mask reset
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_UNF_BIT = 1;
    localparam logic [1:0] IRQMASK_RESET = 2'h0;

    // Output pin signal codes
    localparam logic [5:0] PINSEL_RX_THR = 6'h00;
    localparam logic [5:0] PINSEL_TX_THR = 6'h02;

    // Threshold arithmetic
    localparam logic [6:0] RX_THR_BASE = 7'h04;
    localparam logic [6:0] TX_THR_BASE = 7'h3D;

    // Header status byte: direction flag above the fill count
    localparam int HDR_WRITE_BIT = 7;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } rpf_bus_e;
endpackage

// ==== design/rpf_fifo_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Owner side pushes, pops and flushes; the store answers with data and level
interface rpf_fifo_if;
    logic push;
    logic pop;
    logic flush;
    logic [7:0] pushData;
    logic [7:0] popData;
    logic [6:0] count;
    logic full;
    logic empty;
    modport owner(output push, output pop, output flush, output pushData,
        input popData, input count, input full, input empty);
    modport store(input push, input pop, input flush, input pushData,
        output popData, output count, output full, output empty);
endinterface
`default_nettype wire

// ==== design/rpf_byte_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module rpf_byte_fifo (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Queue port
    rpf_fifo_if.store port
);
    logic [7:0] mem [0:rpf_pkg::DEPTH-1]; // Byte storage
    logic [5:0] wrPtr; // Next slot to fill
    logic [5:0] rdPtr; // Oldest stored byte
    logic [6:0] count; // Bytes held
    logic doPush;
    logic doPop;

    // Full pushes and empty pops are dropped here; the owner flags only radio-side ones
    assign doPush = port.push && (count != rpf_pkg::DEPTH_CNT) && !port.flush;
    assign doPop = port.pop && (count != 7'h00) && !port.flush;

    assign port.popData = mem[rdPtr];
    assign port.count = count;
    assign port.full = (count == rpf_pkg::DEPTH_CNT);
    assign port.empty = (count == 7'h00);

    // Storage write, no reset needed on data
    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr] <= port.pushData;
        end
    end

    // Pointers and level; both ends may move in one cycle, but a full queue drops a push even when a pop comes with it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= 6'h00;
            rdPtr <= 6'h00;
            count <= 7'h00;
        end else if (port.flush) begin
            // Flush drops everything held
            wrPtr <= 6'h00;
            rdPtr <= 6'h00;
            count <= 7'h00;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 6'h01;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 6'h01;
            end
            if (doPush && !doPop) begin
                count <= count + 7'h01;
            end else if (doPop && !doPush) begin
                count <= count - 7'h01;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_countStep;
        doPush && !port.pop |=> count == $past(count) + 7'h01;
    endproperty
    a_countStep: assert property (p_countStep) else $error("level not raised by push");

    property p_flushClears;
        port.flush |=> count == 7'h00 ##1 (count <= 7'h01);
    endproperty
    a_flushClears: assert property (p_flushClears) else $error("flush left bytes");
endmodule
`default_nettype wire

// ==== design/rpf_packet_fifo_pair.sv ====
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Two independent 64-byte queues, receive and transmit
// - Host pops receive queue, pushes transmit queue only
// - Flag receive overflow and transmit underflow
// - Header status byte carries direction's fill level
// - Both fill counts readable as status fields
// - Four-bit select picks one of sixteen thresholds
// - Receive 4(s+1), transmit 61-4s, mirrored margins
// - Indicator high while count at or above threshold
// - Pin code 0x00 receive, 0x02 transmit indicator
// - Sleep empties both queues
module rpf_packet_fifo_pair (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Radio side link, asynchronous to clock
    input wire logic radioClk,
    input wire logic radioRxValid,
    input wire logic [7:0] radioRxData,
    input wire logic radioTxReq,
    output logic [7:0] radioTxData,
    output logic radioTxValid,
    // Interrupt and general output pin
    output logic irq,
    output logic generalOutputPin
);
    rpf_fifo_if rxIf();
    rpf_fifo_if txIf();

    rpf_pkg::rpf_bus_e busState; // Bus handshake state
    logic [2:0] clkSync; // Radio clock sampler, bit 2 is the edge reference
    logic [1:0] rxValidSync; // Receive strobe sampler
    logic [1:0] txReqSync; // Transmit request sampler
    logic [7:0] rxDataSync1; // First data stage, read only by the second
    logic [7:0] rxDataSync2;
    logic [3:0] fifo_threshold_select; // Shared threshold setting
    logic [5:0] output_pin_signal_select; // Pin source code
    logic sleepMode; // Held low power state
    logic rxOverflow; // Sticky receive overflow
    logic txUnderflow; // Sticky transmit underflow
    logic [1:0] irqStatus; // Event bits, write one to clear
    logic [1:0] irqMask; // Event enables
    logic [7:0] hdrStatus; // Status byte of last data access
    logic [31:0] readMux;
    logic [7:0] addr;
    logic wbReq;
    logic hostPop;
    logic hostPush;
    logic cfgWrite;
    logic radioEdge;
    logic rxEvent;
    logic txEvent;
    logic flushRx;
    logic flushTx;
    logic [6:0] rxThreshold;
    logic [6:0] txThreshold;
    logic rxAtThr;
    logic txAtThr;
    logic [1:0] irqSet;
    logic [1:0] irqClear;
    logic [1:0] next_irqStatus;

    // Queue instances
    rpf_byte_fifo rxFifo (
        .clock(clock),
        .arst_n(arst_n),
        .port(rxIf.store)
    );
    rpf_byte_fifo txFifo (
        .clock(clock),
        .arst_n(arst_n),
        .port(txIf.store)
    );

    // Request decode; address compared on word boundary
    assign addr = {wb_adr_i[7:2], 2'b00};
    assign wbReq = wb_cyc_i && wb_stb_i && (busState == rpf_pkg::BUS_IDLE);
    assign hostPop = wbReq && !wb_we_i && (addr == rpf_pkg::ADDR_RXDATA) && wb_sel_i[0];
    assign hostPush = wbReq && wb_we_i && (addr == rpf_pkg::ADDR_TXDATA) && wb_sel_i[0];
    assign cfgWrite = wbReq && wb_we_i && (addr == rpf_pkg::ADDR_CONFIG);

    // Flush on command or for as long as sleep is held
    assign flushRx = sleepMode || (cfgWrite && wb_sel_i[0] && wb_dat_i[rpf_pkg::CFG_FLUSH_RX_BIT]);
    assign flushTx = sleepMode || (cfgWrite && wb_sel_i[0] && wb_dat_i[rpf_pkg::CFG_FLUSH_TX_BIT]);

    // Radio events on the sampled rising edge of the link clock
    assign radioEdge = clkSync[1] && !clkSync[2];
    assign rxEvent = radioEdge && rxValidSync[1];
    assign txEvent = radioEdge && txReqSync[1];

    // Queue port drive
    assign rxIf.push = rxEvent;
    assign rxIf.pushData = rxDataSync2;
    assign rxIf.pop = hostPop;
    assign rxIf.flush = flushRx;
    assign txIf.push = hostPush; // Full pushes dropped, host must avoid them
    assign txIf.pushData = wb_dat_i[7:0];
    assign txIf.pop = txEvent;
    assign txIf.flush = flushTx;

    // Mirrored thresholds from one setting
    assign rxThreshold = {1'b0, fifo_threshold_select, 2'b00} + rpf_pkg::RX_THR_BASE;
    assign txThreshold = rpf_pkg::TX_THR_BASE - {1'b0, fifo_threshold_select, 2'b00};
    assign rxAtThr = (rxIf.count >= rxThreshold);
    assign txAtThr = (txIf.count >= txThreshold);

    // Two-flop sampling of every link input; only stage 1 reads stage 0
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clkSync <= 3'h0;
            rxValidSync <= 2'h0;
            txReqSync <= 2'h0;
            rxDataSync1 <= 8'h00;
            rxDataSync2 <= 8'h00;
        end else begin
            clkSync <= {clkSync[1:0], radioClk};
            rxValidSync <= {rxValidSync[0], radioRxValid};
            txReqSync <= {txReqSync[0], radioTxReq};
            rxDataSync1 <= radioRxData;
            rxDataSync2 <= rxDataSync1;
        end
    end

    // Bus handshake: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busState <= rpf_pkg::BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            unique case (busState)
                rpf_pkg::BUS_IDLE: begin
                    if (wbReq) begin
                        busState <= rpf_pkg::BUS_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                rpf_pkg::BUS_ACK: begin
                    // Always back to idle, so ack is a single cycle
                    busState <= rpf_pkg::BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // Read data selection; unmapped reads return zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (addr)
            rpf_pkg::ADDR_RXDATA: begin
                // Empty reads give zero rather than stale bytes
                readMux[7:0] = rxIf.empty ? 8'h00 : rxIf.popData;
            end
            rpf_pkg::ADDR_COUNTS: begin
                readMux[rpf_pkg::COUNTS_RX_LSB +: 7] = rxIf.count;
                readMux[rpf_pkg::COUNTS_TX_LSB +: 7] = txIf.count;
                readMux[rpf_pkg::COUNTS_OVF_BIT] = rxOverflow;
                readMux[rpf_pkg::COUNTS_UNF_BIT] = txUnderflow;
            end
            rpf_pkg::ADDR_CONFIG: begin
                readMux[rpf_pkg::CFG_THR_LSB +: 4] = fifo_threshold_select;
                readMux[rpf_pkg::CFG_SLEEP_BIT] = sleepMode;
                readMux[rpf_pkg::CFG_PINSEL_LSB +: 6] = output_pin_signal_select;
            end
            rpf_pkg::ADDR_IRQSTAT: begin
                readMux[1:0] = irqStatus;
            end
            rpf_pkg::ADDR_IRQMASK: begin
                readMux[1:0] = irqMask;
            end
            rpf_pkg::ADDR_HDRSTAT: begin
                readMux[7:0] = hdrStatus;
            end
            default: begin
                readMux = 32'h0000_0000;
            end
        endcase
    end

    // Read data latched with the ack
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbReq && !wb_we_i) begin
            wb_dat_o <= readMux;
        end
    end

    // Configuration register, byte lanes honoured
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fifo_threshold_select <= rpf_pkg::THR_RESET;
            sleepMode <= 1'b0;
            output_pin_signal_select <= rpf_pkg::PINSEL_RESET;
        end else if (cfgWrite) begin
            if (wb_sel_i[0]) begin
                fifo_threshold_select <= wb_dat_i[rpf_pkg::CFG_THR_LSB +: 4];
                sleepMode <= wb_dat_i[rpf_pkg::CFG_SLEEP_BIT];
            end
            if (wb_sel_i[1]) begin
                output_pin_signal_select <= wb_dat_i[rpf_pkg::CFG_PINSEL_LSB +: 6];
            end
        end
    end

    // Status byte of the last data access: direction plus that queue's level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hdrStatus <= 8'h00;
        end else if (hostPop) begin
            hdrStatus <= {1'b0, rxIf.count};
        end else if (hostPush) begin
            hdrStatus <= {1'b1, txIf.count};
        end
    end

    // Sticky error flags; a new error wins over a coincident flush
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxOverflow <= 1'b0;
            txUnderflow <= 1'b0;
        end else begin
            if (rxEvent && rxIf.full) begin
                rxOverflow <= 1'b1;
            end else if (flushRx) begin
                rxOverflow <= 1'b0;
            end
            if (txEvent && txIf.empty) begin
                txUnderflow <= 1'b1;
            end else if (flushTx) begin
                txUnderflow <= 1'b0;
            end
        end
    end

    // Interrupt status: set beats a same-cycle write-one clear
    assign irqSet = {txEvent && txIf.empty, rxEvent && rxIf.full};
    assign irqClear = (wbReq && wb_we_i && (addr == rpf_pkg::ADDR_IRQSTAT) && wb_sel_i[0])
        ? wb_dat_i[1:0] : 2'h0;
    assign next_irqStatus = (irqStatus & ~irqClear) | irqSet;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus <= 2'h0;
            irqMask <= rpf_pkg::IRQMASK_RESET;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wbReq && wb_we_i && (addr == rpf_pkg::ADDR_IRQMASK) && wb_sel_i[0]) begin
                irqMask <= wb_dat_i[1:0];
            end
            // Registered output, so it trails status by one cycle
            irq <= |(irqStatus & irqMask);
        end
    end

    // Transmit byte handed to the radio on each request
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            radioTxData <= 8'h00;
            radioTxValid <= 1'b0;
        end else if (txEvent) begin
            radioTxData <= txIf.empty ? 8'h00 : txIf.popData;
            radioTxValid <= !txIf.empty;
        end
    end

    // Pin source select; unknown codes drive low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            generalOutputPin <= 1'b0;
        end else if (output_pin_signal_select == rpf_pkg::PINSEL_RX_THR) begin
            generalOutputPin <= rxAtThr;
        end else if (output_pin_signal_select == rpf_pkg::PINSEL_TX_THR) begin
            generalOutputPin <= txAtThr;
        end else begin
            generalOutputPin <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ackPulse;
        s_busReq |=> s_ackPulse;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack not one cycle");

    property p_overflowSet;
        rxEvent && rxIf.full |=> rxOverflow && irqStatus[rpf_pkg::IRQ_OVF_BIT];
    endproperty
    a_overflowSet: assert property (p_overflowSet) else $error("overflow missed");

    property p_underflowSet;
        txEvent && txIf.empty |=> txUnderflow && !radioTxValid;
    endproperty
    a_underflowSet: assert property (p_underflowSet) else $error("underflow missed");

    property p_flagHold;
        rxOverflow && !flushRx |=> rxOverflow;
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("overflow dropped early");

    property p_sleepEmpty;
        sleepMode |=> (rxIf.count == 7'h00) && (txIf.count == 7'h00);
    endproperty
    a_sleepEmpty: assert property (p_sleepEmpty) else $error("queue kept in sleep");

    property p_rxPin;
        (output_pin_signal_select == rpf_pkg::PINSEL_RX_THR) && (rxIf.count >= rxThreshold)
            |=> generalOutputPin;
    endproperty
    a_rxPin: assert property (p_rxPin) else $error("receive indicator low");

    property p_txPin;
        (output_pin_signal_select == rpf_pkg::PINSEL_TX_THR) && (txIf.count < txThreshold)
            |=> !generalOutputPin;
    endproperty
    a_txPin: assert property (p_txPin) else $error("transmit indicator high");

    property p_hdrRead;
        hostPop |=> hdrStatus == {1'b0, $past(rxIf.count)};
    endproperty
    a_hdrRead: assert property (p_hdrRead) else $error("status byte wrong");

    property p_irqOut;
        (irqStatus & irqMask) != 2'h0 |=> irq;
    endproperty
    a_irqOut: assert property (p_irqOut) else $error("interrupt not raised");
endmodule
`default_nettype wire

// ==== verification/rpf_radio_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Radio side of the link; its clock stands still between bytes
module rpf_radio_model (
    // Link toward the block
    output logic radioClk,
    output logic radioRxValid,
    output logic [7:0] radioRxData,
    output logic radioTxReq,
    // Link from the block
    input wire logic [7:0] radioTxData,
    input wire logic radioTxValid
);
    // Idle link: clock low, nothing offered
    initial begin
        radioClk = 1'b0;
        radioRxValid = 1'b0;
        radioRxData = 8'h00;
        radioTxReq = 1'b0;
    end

    // One received byte per 400 ns period, even into a full queue
    task automatic rx_byte(input logic [7:0] d);
        radioRxValid = 1'b1;
        radioRxData = d;
        #213 radioClk = 1'b1;
        // Held past the synchroniser, released before the next byte starts
        #174 radioClk = 1'b0;
        radioRxValid = 1'b0;
        // Stale byte inverted so it never passes for fresh data
        radioRxData = ~d;
        #13;
    endtask

    // Ask for one transmit byte; sample once the answer has settled
    task automatic tx_byte(output logic [7:0] d, output logic v);
        radioTxReq = 1'b1;
        #213 radioClk = 1'b1;
        #174 radioClk = 1'b0;
        radioTxReq = 1'b0;
        #13 d = radioTxData;
        v = radioTxValid;
    endtask
endmodule
`default_nettype wire

// ==== verification/radio_packet_fifo_pair_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// Queue models of both byte stores compared with the block
module radio_packet_fifo_pair_bench;
    // Clock, reset and bus master
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    // Link and output pins
    logic radioClk, radioRxValid, radioTxReq, radioTxValid;
    logic [7:0] radioRxData, radioTxData;
    logic irq, generalOutputPin;
    // Reference queues, random source, tallies
    logic [7:0] rxQ[$];
    logic [7:0] txQ[$];
    logic [31:0] seed = 32'h1DCD;
    int failures = 0;
    int testsRun = 0;

    always #25 clock = ~clock;

    rpf_packet_fifo_pair rpf_packet_fifo_pair_inst (.clock(clock), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .radioClk(radioClk),
        .radioRxValid(radioRxValid), .radioRxData(radioRxData), .radioTxReq(radioTxReq),
        .radioTxData(radioTxData), .radioTxValid(radioTxValid), .irq(irq),
        .generalOutputPin(generalOutputPin));

    rpf_radio_model rpf_radio_model_inst (.radioClk(radioClk),
        .radioRxValid(radioRxValid), .radioRxData(radioRxData), .radioTxReq(radioTxReq),
        .radioTxData(radioTxData), .radioTxValid(radioTxValid));

    // Xorshift byte source
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Verdict, reached from the main sequence or a spent bound
    task automatic final_report();
        $display("checks %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        testsRun++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        // A slave that never answers ends the run
        if (ack !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: bus timeout", $time);
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    // Pin and irq are registered, so give them a few cycles
    // Sampled only after the wait, once the registered output has settled
    task automatic chkPin(input bit onIrq, input logic e, input string m);
        repeat (3) @(posedge clock);
        chk({31'h0, onIrq ? irq : generalOutputPin}, {31'h0, e}, m);
    endtask

    // Every select value against one fixed fill level
    task automatic sweep(input logic [5:0] pin, input int cnt);
        int t;
        for (int s = 0; s < 16; s++) begin
            t = (pin == rpf_pkg::PINSEL_TX_THR) ? 61 - 4 * s : 4 * (s + 1);
            wr(rpf_pkg::ADDR_CONFIG, {18'h0, pin, 4'h0, s[3:0]});
            chkPin(1'b0, cnt >= t, "threshold pin");
        end
    endtask

    // Run length cap
    initial begin
        #4000000;
        failures++;
        $display("mismatch at %0t: run limit reached", $time);
        final_report();
    end

    initial begin
        logic [31:0] q;
        logic [7:0] d;
        logic v;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values; wrong-direction and unmapped places move nothing
        rd(rpf_pkg::ADDR_CONFIG, q);
        chk(q & 32'h3F7F, {18'h0, rpf_pkg::PINSEL_RESET, 4'h0, rpf_pkg::THR_RESET}, "cfg");
        rd(rpf_pkg::ADDR_IRQMASK, q);
        chk(q[1:0], rpf_pkg::IRQMASK_RESET, "mask reset");
        wr(rpf_pkg::ADDR_RXDATA, 32'h5A);
        rd(8'h1C, q);
        chk(q, 32'h0, "unmapped read");
        rd(rpf_pkg::ADDR_TXDATA, q);
        chk(q, 32'h0, "tx data read");
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q, 32'h0, "counts after reset");
        $display("test reset done");
        // Fill the transmit queue, one write past full on purpose
        for (int i = 0; i < 65; i++) begin
            d = rnd();
            if (i == 33) sweep(rpf_pkg::PINSEL_TX_THR, 33);
            wr(rpf_pkg::ADDR_TXDATA, {24'h0, d});
            if (txQ.size() < 64) txQ.push_back(d);
            rd(rpf_pkg::ADDR_HDRSTAT, q);
            chk(q[7:0], {1'b1, (i > 63) ? rpf_pkg::DEPTH_CNT : 7'(i)}, "hdr tx");
        end
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q[14:8], rpf_pkg::DEPTH_CNT, "tx full count");
        $display("test tx fill done");
        // Radio drains it, then asks once more from empty
        for (int i = 0; i < 65; i++) begin
            rpf_radio_model_inst.tx_byte(d, v);
            if (txQ.size() > 0) begin
                chk({23'h0, v, d}, {23'h0, 1'b1, txQ.pop_front()}, "tx byte");
            end else begin
                chk({31'h0, v}, 32'h0, "tx underflow valid");
            end
        end
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q[17:16], 2'b10, "underflow flag");
        rd(rpf_pkg::ADDR_IRQSTAT, q);
        chk(q[1:0], 2'b10, "underflow status");
        chkPin(1'b1, 1'b0, "irq masked");
        wr(rpf_pkg::ADDR_IRQMASK, 32'h3);
        chkPin(1'b1, 1'b1, "irq unmasked");
        wr(rpf_pkg::ADDR_IRQSTAT, 32'h2);
        chkPin(1'b1, 1'b0, "irq cleared");
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q[17], 1'b1, "underflow sticky");
        wr(rpf_pkg::ADDR_CONFIG, 32'h47);
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q, 32'h0, "tx flushed");
        $display("test tx drain done");
        // Short packet read only after it is complete
        for (int i = 0; i < 40; i++) begin
            if (i == 32) sweep(rpf_pkg::PINSEL_RX_THR, 32);
            d = rnd();
            rpf_radio_model_inst.rx_byte(d);
            rxQ.push_back(d);
        end
        repeat (4) @(posedge clock);
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q[6:0], 7'h28, "rx count");
        for (int i = 40; i > 0; i--) begin
            rd(rpf_pkg::ADDR_RXDATA, q);
            chk(q[7:0], rxQ.pop_front(), "rx byte");
            rd(rpf_pkg::ADDR_HDRSTAT, q);
            chk(q[7:0], {1'b0, 7'(i)}, "hdr rx");
        end
        $display("test rx packet done");
        // Long packet drained while it arrives, one byte left behind until the rest has all arrived
        fork
            begin
                logic [7:0] b;
                for (int i = 0; i < 80; i++) begin
                    b = rnd();
                    rxQ.push_back(b);
                    rpf_radio_model_inst.rx_byte(b);
                end
            end
            begin
                int left;
                int n;
                int m;
                left = 80;
                for (int k = 0; k < 2000 && left > 0; k++) begin
                    rd(rpf_pkg::ADDR_COUNTS, q);
                    n = q[6:0];
                    rd(rpf_pkg::ADDR_COUNTS, q);
                    // Two equal readings give a level that can be trusted
                    if (q[6:0] == n) begin
                        m = (n < left) ? n - 1 : left;
                        for (int j = 0; j < m; j++) begin
                            rd(rpf_pkg::ADDR_RXDATA, q);
                            chk(q[7:0], rxQ.pop_front(), "long rx byte");
                            left--;
                        end
                    end
                end
                chk(left, 0, "long rx left");
            end
        join
        $display("test long packet done");
        // Overflow the receive queue, then sleep empties both
        for (int i = 0; i < 65; i++) rpf_radio_model_inst.rx_byte(rnd());
        repeat (4) @(posedge clock);
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q, 32'h00010040, "overflow flag");
        chkPin(1'b1, 1'b1, "irq overflow");
        wr(rpf_pkg::ADDR_IRQSTAT, 32'h1);
        chkPin(1'b1, 1'b0, "irq overflow cleared");
        wr(rpf_pkg::ADDR_TXDATA, 32'hA5);
        wr(rpf_pkg::ADDR_CONFIG, 32'h27);
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q, 32'h00000100, "rx flushed");
        rpf_radio_model_inst.rx_byte(8'h3C);
        wr(rpf_pkg::ADDR_CONFIG, 32'h17);
        wr(rpf_pkg::ADDR_CONFIG, 32'h07);
        rd(rpf_pkg::ADDR_COUNTS, q);
        chk(q, 32'h0, "sleep empties");
        $display("test overflow and sleep done");
        final_report();
    end
endmodule
`default_nettype wire
